// File: core/btu_branch_target_unit.v
`timescale 1ns/1ps
`include "btu_defines.vh"

module btu_branch_target_unit #(
    parameter ADDR_W = 32
) (
    input  wire                    clk,
    input  wire                    rstn,
    input  wire                    issue_valid,
    input  wire [`BTU_KIND_W-1:0]  issue_kind,
    input  wire                    issue_bundled,
    input  wire [ADDR_W-1:0]       issue_pc,
    input  wire [ADDR_W-1:0]       pointer_value,
    input  wire [`BTU_LONG_W-1:0]  displacement,
    input  wire                    branch_on_false,
    input  wire                    predict_taken_hint,
    input  wire                    condition_flag,
    input  wire [3:0]              status_flags_in,
    output reg                     pc_load,
    output reg  [ADDR_W-1:0]       pc_next,
    output reg  [2:0]              insn_length,
    output reg                     predict_taken,
    output reg  [ADDR_W-1:0]       predict_target,
    output reg                     flush,
    output reg                     align_fault,
    output reg                     bundle_fault,
    output reg  [3:0]              status_flags_out,
    output reg                     state_busy
);

// ----------------------------------------
// target arithmetic
// ----------------------------------------
wire [ADDR_W-1:0] short_displacement = {{(ADDR_W-`BTU_SHORT_W){
    displacement[`BTU_SHORT_W-1]}}, displacement[`BTU_SHORT_W-1:1], 1'b0};
wire [ADDR_W-1:0] long_displacement = {{(ADDR_W-`BTU_LONG_W){
    displacement[`BTU_LONG_W-1]}}, displacement[`BTU_LONG_W-1:1], 1'b0};
wire [ADDR_W-1:0] conditional_displacement = {{(ADDR_W-`BTU_COND_W){
    displacement[`BTU_COND_W-1]}}, displacement[`BTU_COND_W-1:1], 1'b0};

reg  [ADDR_W-1:0] next_target;
reg  [2:0]        next_len;
reg               next_ptr_form;
reg               next_cond;

always @* begin
    next_target   = issue_pc;
    next_len      = `BTU_LEN_SHORT;
    next_ptr_form = 1'b0;
    next_cond     = 1'b0;
    case (issue_kind)
        `BTU_KIND_IND: begin
            next_target   = pointer_value;
            next_ptr_form = 1'b1;
        end
        `BTU_KIND_IDX: begin
            next_target   = issue_pc + pointer_value;
            next_ptr_form = 1'b1;
        end
        `BTU_KIND_SHORT: begin
            next_target = issue_pc + short_displacement;
        end
        `BTU_KIND_LONG: begin
            next_target = issue_pc + long_displacement;
            next_len    = `BTU_LEN_LONG;
        end
        `BTU_KIND_COND: begin
            next_target = issue_pc + conditional_displacement;
            next_cond   = 1'b1;
        end
        default: next_target = issue_pc;
    endcase
end

// ----------------------------------------
// decode helpers
// ----------------------------------------
wire is_jump   = issue_valid && (issue_kind != `BTU_KIND_NONE);
wire odd_ptr   = next_ptr_form && pointer_value[0];
wire cond_hit  = branch_on_false ? !condition_flag
                                 : condition_flag;
wire [ADDR_W-1:0] seq_pc = issue_pc + {{(ADDR_W-3){1'b0}}, next_len};

// prediction wrong: wrong-path fetches must go
wire mispredict = (cond_hit != predict_taken_hint);

// ----------------------------------------
// one-hot sequencing
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_BUSY = 2'b10;

reg  [1:0]        state;
reg  [1:0]        next_state;
reg               next_pc_load;
reg  [ADDR_W-1:0] next_pc_next;
reg  [2:0]        next_insn_length;
reg               next_predict_taken;
reg  [ADDR_W-1:0] next_predict_target;
reg               next_flush;
reg               next_align_fault;
reg               next_bundle_fault;
reg               next_state_busy;

// ----------------------------------------
// acceptance and outcome
// ----------------------------------------
always @* begin
    next_state          = state;
    next_pc_load        = 1'b0;
    next_pc_next        = pc_next;
    next_insn_length    = insn_length;
    next_predict_taken  = 1'b0;
    next_predict_target = predict_target;
    next_flush          = 1'b0;
    next_align_fault    = 1'b0;
    next_bundle_fault   = 1'b0;
    next_state_busy     = 1'b0;
    case (state)
        ST_IDLE: begin
            if (is_jump) begin
                next_state       = ST_BUSY;
                next_state_busy  = 1'b1;
                next_insn_length = next_len;
                if (issue_bundled) begin
                    next_bundle_fault = 1'b1;
                end else if (odd_ptr) begin
                    next_align_fault = 1'b1;
                end else if (next_cond) begin
                    next_predict_taken  = predict_taken_hint;
                    next_predict_target = predict_taken_hint ?
                                          next_target : seq_pc;
                    next_flush          = mispredict;
                    next_pc_load        = mispredict;
                    next_pc_next        = cond_hit ? next_target
                                                   : seq_pc;
                end else begin
                    next_pc_load = 1'b1;
                    next_flush   = 1'b1;
                    next_pc_next = next_target;
                end
            end
        end
        ST_BUSY: begin
            // one dead cycle; requests here are ignored
            next_state = ST_IDLE;
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

// ----------------------------------------
// output registers
// ----------------------------------------
always @(posedge clk) begin
    if (!rstn) begin
        state          <= ST_IDLE;
        pc_load        <= 1'b0;
        pc_next        <= {ADDR_W{1'b0}};
        insn_length    <= 3'h0;
        predict_taken  <= 1'b0;
        predict_target <= {ADDR_W{1'b0}};
        flush          <= 1'b0;
        align_fault    <= 1'b0;
        bundle_fault   <= 1'b0;
        state_busy     <= 1'b0;
    end else begin
        state          <= next_state;
        pc_load        <= next_pc_load;
        pc_next        <= next_pc_next;
        insn_length    <= next_insn_length;
        predict_taken  <= next_predict_taken;
        predict_target <= next_predict_target;
        flush          <= next_flush;
        align_fault    <= next_align_fault;
        bundle_fault   <= next_bundle_fault;
        state_busy     <= next_state_busy;
    end
end

// ----------------------------------------
// status flags
// ----------------------------------------
// jumps never touch the arithmetic flags; plain one-cycle copy
always @(posedge clk) begin
    if (!rstn) begin
        status_flags_out <= 4'h0;
    end else begin
        status_flags_out <= status_flags_in;
    end
end

endmodule // btu_branch_target_unit

// File: core/btu_defines.vh
`ifndef BTU_DEFINES_VH
`define BTU_DEFINES_VH

// ----------------------------------------
// jump kinds, one-hot
// ----------------------------------------
`define BTU_KIND_W        6
`define BTU_KIND_NONE     6'h01
`define BTU_KIND_IND      6'h02
`define BTU_KIND_IDX      6'h04
`define BTU_KIND_SHORT    6'h08
`define BTU_KIND_LONG     6'h10
`define BTU_KIND_COND     6'h20

// ----------------------------------------
// displacement widths and lengths
// ----------------------------------------
`define BTU_SHORT_W       13
`define BTU_LONG_W        25
`define BTU_COND_W        11
`define BTU_LEN_SHORT     3'h2
`define BTU_LEN_LONG      3'h4

// ----------------------------------------
// states, one-hot
// ----------------------------------------
`define BTU_ST_IDLE       2'h1
`define BTU_ST_BUSY       2'h2

`endif

// File: dv/btu_fetch_model.sv
`timescale 1ns/1ps
module btu_fetch_model (input logic clk, pc_load,
    input logic [31:0] pc_next, output logic [31:0] fetch_pc);
always @(posedge clk) if (pc_load) fetch_pc <= pc_next;
endmodule // btu_fetch_model

// File: dv/btu_monitor.sv
`timescale 1ns/1ps
`include "btu_defines.vh"
module btu_monitor (input logic clk, rstn, issue_valid, issue_bundled,
    predict_taken_hint, pc_load, predict_taken, align_fault, bundle_fault,
    state_busy, input logic [5:0] issue_kind, input logic [2:0] insn_length,
    input logic [31:0] pointer_value, pc_next,
    input logic [3:0] status_flags_in, status_flags_out);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
sequence s_go; issue_valid && !state_busy && !issue_bundled &&
    issue_kind != `BTU_KIND_NONE; endsequence
sequence s_ptr; s_go ##0 issue_kind inside {`BTU_KIND_IND, `BTU_KIND_IDX};
endsequence
AST_BUNDLE: assert property (issue_valid && !state_busy &&
    issue_kind != `BTU_KIND_NONE && issue_bundled
    |=> bundle_fault && !pc_load) else $error("bundle ran");
AST_ALIGN: assert property (s_ptr ##0 pointer_value[0]
    |=> align_fault && !pc_load) else $error("odd pointer ran");
AST_IND: assert property (s_ptr ##0 !pointer_value[0] &&
    issue_kind[1] |=> pc_next == $past(pointer_value)) else $error("ind");
AST_LONG: assert property (s_go ##0 issue_kind == `BTU_KIND_LONG
    |=> pc_load && insn_length == `BTU_LEN_LONG) else $error("long");
AST_SHORT: assert property (s_go ##0 issue_kind == `BTU_KIND_SHORT
    |=> pc_load && insn_length == `BTU_LEN_SHORT) else $error("short");
AST_HINT: assert property (s_go ##0 issue_kind == `BTU_KIND_COND
    |=> predict_taken == $past(predict_taken_hint)) else $error("hint");
AST_FLAGS: assert property ($past(rstn) |->
    status_flags_out == $past(status_flags_in)) else $error("flags");
AST_ONCE: assert property (pc_load |=> !pc_load && !state_busy)
    else $error("load not a pulse");
endmodule // btu_monitor

// File: dv/tb_branch_target_unit.sv
`timescale 1ns/1ps
`include "btu_defines.vh"
module tb_branch_target_unit;
logic clk = 0, rstn = 0, issue_valid = 0, issue_bundled = 0;
logic condition_flag = 0, branch_on_false = 0, predict_taken_hint = 0;
logic pc_load, predict_taken, flush, align_fault, bundle_fault, state_busy;
logic [5:0] issue_kind = 6'h01;
logic [31:0] issue_pc = '0, pointer_value = '0, pc_next, predict_target;
logic [31:0] fetch_pc;
logic [24:0] displacement = '0;
logic [3:0] status_flags_in = 4'ha, status_flags_out;
logic [2:0] insn_length;
int mismatches = 0, total_checks = 0, cyc = 0;
always #50 clk = ~clk;
always @(posedge clk) if (++cyc == 900) begin mismatches++; summarize; end
btu_branch_target_unit uut (.*);
btu_fetch_model fm (.*);
task chk(logic [31:0] g, e);
    total_checks++;
    if (g !== e) mismatches++;
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
endtask
task go(logic [5:0] k, logic [31:0] pc, p, logic [3:0] m);
    @(posedge clk);
    {issue_valid, issue_kind, issue_pc, pointer_value} <= {1'h1, k, pc, p};
    {issue_bundled, condition_flag, branch_on_false, predict_taken_hint} <= m;
    displacement <= p[24:0];
    @(posedge clk) issue_valid <= 1'h0;
    #1;
endtask
task t_rel;
    go(`BTU_KIND_SHORT, 32'h0000_0100, 32'h0000_0224, 4'h0);
    chk(pc_next, 32'h0000_0324);
    @(posedge clk) #1 chk(fetch_pc, 32'h0000_0324);
    go(`BTU_KIND_LONG, 32'h0100_0000, 32'h0100_0000, 4'h0);
    chk(pc_next, '0);
endtask
task t_ptr;
    go(`BTU_KIND_IND, '0, 32'h0000_0400, 4'h0);
    chk(pc_next, 32'h0000_0400);
    go(`BTU_KIND_IDX, 32'h0000_0100, 32'h0000_0020, 4'h0);
    chk(pc_next, 32'h0000_0120);
    go(`BTU_KIND_IDX, 32'h0000_0100, 32'h0000_0021, 4'h0);
    chk({align_fault, pc_load}, 2'h2);
    go(`BTU_KIND_SHORT, '0, 32'h0000_0224, 4'h8);
    chk({bundle_fault, pc_load}, 2'h2);
endtask
task t_cond;
    logic [31:0] f, t;
    f = 32'h0000_1002;
    t = 32'h0000_0c00;
    for (int i = 0; i < 8; i++) begin
        go(`BTU_KIND_COND, 32'h0000_1000, 32'h0000_0400, i[3:0]);
        chk(predict_target, i[0] ? t : f);
        chk({flush, pc_load}, {2{^i[2:0]}});
        if (^i[2:0]) chk(pc_next, i[0] ? f : t);
    end
endtask
task summarize;
    $display("%0d checks %0d errors", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    t_rel;
    t_ptr;
    t_cond;
    summarize;
end
endmodule // tb_branch_target_unit
bind btu_branch_target_unit btu_monitor mon (.*);
